// File: hw/dpx_pkg.sv
// Purpose: Shared constants for the data pointer and expanded RAM access block
// Assumes: Core clock 50 MHz; special registers reached over the core register port
// Notes:   Strobe figures are in core clock periods
`default_nettype none
package dpx_pkg;

    // Special register addresses
    localparam logic [7:0] MEM_CTRL_ADDR = 8'h8E;
    localparam logic [7:0] PTR_BOOT_ADDR = 8'hA2;

    // aux_memory_control field positions
    localparam int MC_LATCH_RESTRICT_BIT = 0;
    localparam int MC_OFF_CHIP_BIT       = 1;
    localparam int MC_SIZE_LO_BIT        = 2;
    localparam int MC_SIZE_HI_BIT        = 3;
    localparam int MC_STRETCH_BIT        = 5;

    // aux_pointer_boot_control field positions
    localparam int PB_SELECT_BIT    = 0;
    localparam int PB_ZERO_BIT      = 2;
    localparam int PB_USER_FLAG_BIT = 3;
    localparam int PB_BOOT_BIT      = 5;

    // Reset values
    localparam logic       MC_STRETCH_RST  = 1'b0;
    localparam logic [1:0] MC_SIZE_RST     = 2'h0;
    localparam logic       MC_RESTRICT_RST = 1'b0;
    localparam logic       MC_OFF_CHIP_RST = 1'b0;
    localparam logic       PB_SELECT_RST   = 1'b0;
    localparam logic       PB_FLAG_RST     = 1'b0;
    localparam logic       PB_BOOT_RST     = 1'b0;
    localparam logic [15:0] DP_RST         = 16'h0000;

    // Strobe widths in clock periods
    localparam logic [4:0] STROBE_SHORT_CLKS = 5'h06;
    localparam logic [4:0] STROBE_LONG_CLKS  = 5'h1E;

    // Latch strobe dividers: standard and double speed
    localparam logic [2:0] ALE_STD_DIV = 3'h6;
    localparam logic [2:0] ALE_X2_DIV  = 3'h3;

    // Memory map
    localparam logic [15:0] BOOT_BASE      = 16'hF800;
    localparam int          EXPANDED_RAM_ADDR_W    = 10;
    localparam int          EXPANDED_RAM_PAGE_BITS = 8;

endpackage : dpx_pkg
`default_nettype wire

// File: hw/dpx_pulse_timer.sv
// Purpose: Holds a strobe active for a loaded number of clock periods
// Assumes: len is at least one
// Notes:   last marks the final active cycle
`timescale 1ns/100ps
`default_nettype none
module dpx_pulse_timer
    import dpx_pkg::*;
#(
    parameter int W = 5
) (
    input  wire logic         clock,
    input  wire logic         rst_b,
    input  wire logic         start,
    input  wire logic [W-1:0] len,
    output logic              active,
    output logic              last
);
    logic [W-1:0] count;
    logic         running;

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            running <= 1'b0;
            count   <= '0;
        end else if (start) begin
            running <= 1'b1;
            count   <= len - W'(1);
        end else if (running) begin
            running <= (count != '0);
            count   <= count - W'(1);
        end
    end

    assign active = running;
    assign last   = running && (count == '0);
endmodule // dpx_pulse_timer
`default_nettype wire

// File: hw/dpx_mem_ctrl.sv
// Purpose: Dual data pointer, boot mapping, expanded RAM and external move control
// Assumes: Core issues one external move at a time and waits for xm_done
// Notes:   Register reads answer one cycle after sfr_rd
`timescale 1ns/100ps
`default_nettype none
module dpx_mem_ctrl
    import dpx_pkg::*;
#(
    parameter int EXPANDED_RAM_BYTES = 1024
) (
    input  wire logic        clock,
    input  wire logic        rst_b,
    input  wire logic        hsb_off_chip,
    input  wire logic        double_speed_mode,
    input  wire logic [7:0]  sfr_addr,
    input  wire logic        sfr_wr,
    input  wire logic [7:0]  sfr_wdata,
    input  wire logic        sfr_rd,
    output logic      [7:0]  sfr_rdata,
    output logic             sfr_hit,
    input  wire logic        dp_load,
    input  wire logic [15:0] dp_load_value,
    input  wire logic        dp_inc,
    output logic      [15:0] data_pointer,
    input  wire logic [15:0] code_addr,
    output logic             boot_rom_sel,
    input  wire logic        iram_req,
    input  wire logic [7:0]  iram_addr,
    input  wire logic        iram_direct,
    input  wire logic        iram_stack,
    output logic             sel_lower_ram,
    output logic             sel_upper_ram,
    output logic             sel_special_reg,
    input  wire logic        xm_req,
    input  wire logic        xm_write,
    input  wire logic        xm_use_ptr,
    input  wire logic [7:0]  xm_ri_addr,
    input  wire logic [7:0]  xm_wdata,
    output logic             xm_ready,
    output logic             xm_done,
    output logic      [7:0]  xm_rdata,
    output logic             xm_external,
    input  wire logic [7:0]  p0_in,
    output logic      [7:0]  p0_out,
    output logic             p0_oe,
    output logic      [7:0]  p2_out,
    output logic             p2_oe,
    output logic             rd_strobe_b,
    output logic             wr_strobe_b,
    output logic             ale
);
    typedef enum logic [2:0] {
        X_IDLE,
        X_INT,
        X_LATCH,
        X_STROBE,
        X_DONE
    } dpx_xstate_e;

    // Control registers
    logic        strobe_stretch;
    logic [1:0]  onchip_size;
    logic        off_chip_select;
    logic        latch_strobe_restrict;
    logic        pointer_select;
    logic        user_flag;
    logic        boot_map_enable;
    logic        strap_taken;
    logic [15:0] data_pointer_zero;
    logic [15:0] data_pointer_one;

    // External move state
    dpx_xstate_e state;
    dpx_xstate_e next_state;
    logic [15:0] xm_addr;
    logic        xm_wr_q;
    logic        xm_ptr_q;
    logic [7:0]  xm_wdata_q;
    logic [7:0]  p0_meta;
    logic [7:0]  p0_sync;
    logic [2:0]  ale_count;
    logic [7:0]  expanded_ram [EXPANDED_RAM_BYTES];

    // Decodes
    wire mc_sel = (sfr_addr == MEM_CTRL_ADDR);
    wire pb_sel = (sfr_addr == PTR_BOOT_ADDR);
    wire mc_wr  = sfr_wr && mc_sel;
    wire pb_wr  = sfr_wr && pb_sel;

    wire [7:0] mc_value = {2'b00, strobe_stretch, 1'b0, onchip_size,
                           off_chip_select, latch_strobe_restrict};
    // Reserved bits read zero; bit 2 forced zero so +1 carries no further
    wire [7:0] pb_value = {2'b00, boot_map_enable, 1'b0, user_flag,
                           1'b0, 1'b0, pointer_select};

    wire [15:0] selected_ptr = pointer_select ? data_pointer_one
                                              : data_pointer_zero;

    // Size limit in bytes: (field + 1) pages of 256
    wire [EXPANDED_RAM_ADDR_W:0] expanded_ram_limit =
        {(EXPANDED_RAM_ADDR_W - 1)'(onchip_size) + (EXPANDED_RAM_ADDR_W - 1)'(1),
         2'b00} << (EXPANDED_RAM_PAGE_BITS - 2);
    wire [15:0] req_addr = xm_use_ptr ? selected_ptr : {8'h00, xm_ri_addr};
    // Register-indirect addresses never exceed 255, so stay on chip unless off_chip_select is set
    wire req_onchip = !off_chip_select
        && (!xm_use_ptr || (req_addr < {5'h00, expanded_ram_limit}));
    wire xm_take = xm_req && (state == X_IDLE);

    wire [4:0] strobe_len = strobe_stretch ? STROBE_LONG_CLKS
                                           : STROBE_SHORT_CLKS;
    wire strobe_active;
    wire strobe_last;
    wire strobe_start = (state == X_LATCH);

    dpx_pulse_timer #(
        .W      (5)
    ) u_strobe (
        .clock  (clock),
        .rst_b  (rst_b),
        .start  (strobe_start),
        .len    (strobe_len),
        .active (strobe_active),
        .last   (strobe_last)
    );

    // Boot ROM window covers the top of program space
    assign boot_rom_sel = boot_map_enable && (code_addr >= BOOT_BASE);

    // Internal RAM routing; stack is always indirect internal RAM
    wire upper_half = iram_addr[7];
    assign sel_lower_ram   = iram_req && !upper_half;
    assign sel_special_reg = iram_req && upper_half && iram_direct && !iram_stack;
    assign sel_upper_ram   = iram_req && upper_half && (!iram_direct || iram_stack);

    // Register file
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            strobe_stretch        <= MC_STRETCH_RST;
            onchip_size           <= MC_SIZE_RST;
            latch_strobe_restrict <= MC_RESTRICT_RST;
            pointer_select        <= PB_SELECT_RST;
            user_flag             <= PB_FLAG_RST;
            boot_map_enable       <= PB_BOOT_RST;
        end else begin
            if (mc_wr) begin
                strobe_stretch        <= sfr_wdata[MC_STRETCH_BIT];
                onchip_size           <= {sfr_wdata[MC_SIZE_HI_BIT],
                                          sfr_wdata[MC_SIZE_LO_BIT]};
                latch_strobe_restrict <= sfr_wdata[MC_LATCH_RESTRICT_BIT];
            end
            if (pb_wr) begin
                pointer_select  <= sfr_wdata[PB_SELECT_BIT];
                user_flag       <= sfr_wdata[PB_USER_FLAG_BIT];
                boot_map_enable <= sfr_wdata[PB_BOOT_BIT];
            end
        end
    end

    // Security byte strap is taken on the first edge after reset release
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            strap_taken     <= 1'b0;
            off_chip_select <= MC_OFF_CHIP_RST;
        end else begin
            strap_taken <= 1'b1;
            if (!strap_taken) begin
                off_chip_select <= hsb_off_chip;
            end else if (mc_wr) begin
                off_chip_select <= sfr_wdata[MC_OFF_CHIP_BIT];
            end
        end
    end

    // Register read port
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            sfr_rdata <= 8'h00;
            sfr_hit   <= 1'b0;
        end else begin
            sfr_hit   <= sfr_rd && (mc_sel || pb_sel);
            sfr_rdata <= !sfr_rd ? 8'h00 : mc_sel ? mc_value
                       : pb_sel ? pb_value : 8'h00;
        end
    end

    // Data pointers: only the selected one moves
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            data_pointer_zero <= DP_RST;
            data_pointer_one  <= DP_RST;
        end else if (dp_load || dp_inc) begin
            if (pointer_select) begin
                data_pointer_one  <= dp_load ? dp_load_value
                                             : data_pointer_one + 16'h0001;
            end else begin
                data_pointer_zero <= dp_load ? dp_load_value
                                             : data_pointer_zero + 16'h0001;
            end
        end
    end

    assign data_pointer = selected_ptr;

    // Pin input synchroniser
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            p0_meta <= 8'h00;
            p0_sync <= 8'h00;
        end else begin
            p0_meta <= p0_in;
            p0_sync <= p0_meta;
        end
    end

    // External move sequencer
    always_comb begin
        next_state = state;
        unique case (state)
            X_IDLE:   if (xm_req) next_state = req_onchip ? X_INT : X_LATCH;
            X_INT:    next_state = X_DONE;
            X_LATCH:  next_state = X_STROBE;
            X_STROBE: if (strobe_last) next_state = X_DONE;
            X_DONE:   next_state = X_IDLE;
        endcase
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            state <= X_IDLE;
        end else begin
            state <= next_state;
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            xm_addr     <= 16'h0000;
            xm_wr_q     <= 1'b0;
            xm_ptr_q    <= 1'b0;
            xm_wdata_q  <= 8'h00;
            xm_external <= 1'b0;
        end else if (xm_take) begin
            xm_addr     <= req_addr;
            xm_wr_q     <= xm_write;
            xm_ptr_q    <= xm_use_ptr;
            xm_wdata_q  <= xm_wdata;
            xm_external <= !req_onchip;
        end
    end

    // On-chip expanded RAM; index is in range since hits are below the limit
    wire [EXPANDED_RAM_ADDR_W-1:0] expanded_ram_index = xm_addr[EXPANDED_RAM_ADDR_W-1:0];

    always_ff @(posedge clock) begin
        if (state == X_INT && xm_wr_q) begin
            expanded_ram[expanded_ram_index] <= xm_wdata_q;
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            xm_rdata <= 8'h00;
        end else if (state == X_INT && !xm_wr_q) begin
            xm_rdata <= expanded_ram[expanded_ram_index];
        end else if (state == X_STROBE && strobe_last && !xm_wr_q) begin
            // Synchronised pin value lags two cycles, still within the strobe
            xm_rdata <= p0_sync;
        end
    end

    // Bus pin drive: address on latch cycle, write data during strobe
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            p0_out <= 8'h00;
            p2_out <= 8'h00;
        end else if (xm_take && !req_onchip) begin
            p0_out <= req_addr[7:0];
            p2_out <= req_addr[15:8];
        end else if (state == X_LATCH) begin
            p0_out <= xm_wdata_q;
        end
    end

    wire bus_cycle = (state == X_LATCH) || (state == X_STROBE);
    assign p0_oe = (state == X_LATCH) || (state == X_STROBE && xm_wr_q);
    // Register-indirect form leaves port 2 free for paging
    assign p2_oe = bus_cycle && xm_ptr_q;
    assign rd_strobe_b = !(state == X_STROBE && strobe_active && !xm_wr_q);
    assign wr_strobe_b = !(state == X_STROBE && strobe_active && xm_wr_q);

    assign xm_ready = (state == X_IDLE);
    assign xm_done  = (state == X_DONE);

    // Free-running latch strobe divider
    wire [2:0] ale_div = double_speed_mode ? ALE_X2_DIV : ALE_STD_DIV;
    wire       ale_tick = (ale_count == 3'h0);

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            ale_count <= 3'h0;
        end else if (ale_tick || ale_count >= ale_div) begin
            ale_count <= ale_div - 3'h1;
        end else begin
            ale_count <= ale_count - 3'h1;
        end
    end

    // Pulses stop during a strobe so the latched address is not disturbed
    assign ale = (state == X_LATCH)
              || (!latch_strobe_restrict && ale_tick && state != X_STROBE);
endmodule // dpx_mem_ctrl
`default_nettype wire

// File: dv/dpx_mem_chk.sv
// Purpose: Port checks of the memory access block
// Assumes: Strobe and latch settings change only while idle
// Notes:   Shadows follow writes to the control register
`timescale 1ns/100ps
`default_nettype none
module dpx_mem_chk
    import dpx_pkg::*;
(
    input wire logic        clock,
    input wire logic        rst_b,
    input wire logic        double_speed_mode,
    input wire logic [7:0]  sfr_addr,
    input wire logic        sfr_wr,
    input wire logic [7:0]  sfr_wdata,
    input wire logic        sfr_rd,
    input wire logic [7:0]  sfr_rdata,
    input wire logic        sfr_hit,
    input wire logic        dp_load,
    input wire logic [15:0] dp_load_value,
    input wire logic        dp_inc,
    input wire logic [15:0] data_pointer,
    input wire logic        xm_req,
    input wire logic        xm_ready,
    input wire logic        xm_use_ptr,
    input wire logic        xm_external,
    input wire logic [7:0]  p0_out,
    input wire logic        p0_oe,
    input wire logic [7:0]  p2_out,
    input wire logic        p2_oe,
    input wire logic        rd_strobe_b,
    input wire logic        wr_strobe_b,
    input wire logic        ale
);
    logic       stretch;
    logic       rs_ale;
    logic [5:0] low_cnt;
    wire        mc_wr = sfr_wr && sfr_addr == MEM_CTRL_ADDR;
    wire        take  = xm_req && xm_ready;
    wire        idle  = rd_strobe_b && wr_strobe_b;
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            stretch <= 1'b0;
            rs_ale  <= 1'b0;
            low_cnt <= 6'h00;
        end else begin
            stretch <= mc_wr ? sfr_wdata[MC_STRETCH_BIT] : stretch;
            rs_ale  <= mc_wr ? sfr_wdata[MC_LATCH_RESTRICT_BIT] : rs_ale;
            low_cnt <= idle ? 6'h00 : low_cnt + 6'h01;
        end
    end
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_b);
    zero_bit_a: assert property (sfr_rd && sfr_addr == PTR_BOOT_ADDR |=>
        sfr_hit && !sfr_rdata[PB_ZERO_BIT]) else $error("bit 2 not zero");
    dp_load_a: assert property (dp_load && !sfr_wr |=>
        data_pointer == $past(dp_load_value)) else $error("load missed");
    dp_inc_a: assert property (dp_inc && !dp_load && !sfr_wr |=>
        data_pointer == $past(data_pointer) + 16'h0001) else $error("inc wrong");
    strobe_len_a: assert property ($rose(idle) |->
        low_cnt == (stretch ? 6'h1E : 6'h06)) else $error("strobe width");
    onchip_pins_a: assert property (take ##1 !xm_external |->
        (idle && !p0_oe && !p2_oe) [*2]) else $error("pins moved");
    ri_no_p2_a: assert property (take && !xm_use_ptr |=>
        !p2_oe [*3]) else $error("port 2 driven");
    ptr_addr_a: assert property (take && xm_use_ptr ##1 xm_external |->
        ale && p0_oe && p2_oe && {p2_out, p0_out} == $past(data_pointer))
        else $error("address phase");
    ale_std_a: assert property (disable iff (!rst_b || rs_ale || double_speed_mode)
        ale && xm_ready |=> !ale [*5] ##1 ale) else $error("latch rate");
    ale_only_a: assert property (rs_ale && ale |-> !xm_ready) else $error("latch idle");
    cover property (take && xm_use_ptr ##1 xm_external);
    cover property (take ##1 !xm_external);
    cover property ($rose(idle) && stretch);
endmodule // dpx_mem_chk
`default_nettype wire

// File: dv/dpx_ext_mem.sv
// Purpose: External data memory on the multiplexed bus
// Assumes: Address taken in the latch cycle
// Notes:   Released port 0 toggles instead of holding
`timescale 1ns/100ps
`default_nettype none
module dpx_ext_mem (
    input  wire logic       clock,
    input  wire logic [7:0] p0_out,
    input  wire logic       p0_oe,
    input  wire logic [7:0] p2_out,
    input  wire logic       p2_oe,
    input  wire logic       rd_strobe_b,
    input  wire logic       wr_strobe_b,
    input  wire logic       ale,
    output logic      [7:0] p0_drv
);
    logic [7:0] mem [256];
    logic [7:0] addr;
    logic [7:0] last = 8'h5A;
    always @(posedge clock) begin
        if (ale && p0_oe) addr <= p0_out ^ (p2_oe ? p2_out : 8'h00);
        if (!wr_strobe_b) mem[addr] <= p0_out;
        last <= rd_strobe_b ? ~last : mem[addr];
    end
    assign p0_drv = rd_strobe_b ? last : mem[addr];
endmodule // dpx_ext_mem
`default_nettype wire

// File: dv/testbench.sv
// Purpose: Self-checking bench of the memory access block
// Assumes: Inputs change on the falling edge
// Notes:   Random values from a shift register seeded at 67
`timescale 1ns/100ps
`default_nettype none
module testbench
    import dpx_pkg::*;
;
    logic        clock, rst_b, hsb_off_chip, double_speed_mode, sfr_wr, sfr_rd, sfr_hit;
    logic [7:0]  sfr_addr, sfr_wdata, sfr_rdata, iram_addr, xm_ri_addr, xm_wdata, xm_rdata;
    logic [7:0]  p0_in, p0_out, p2_out, p0_drv, d;
    logic        dp_load, dp_inc, boot_rom_sel, iram_req, iram_direct, iram_stack;
    logic        sel_lower_ram, sel_upper_ram, sel_special_reg, xm_req, xm_write;
    logic        xm_use_ptr, xm_ready, xm_done, xm_external, p0_oe, p2_oe;
    logic        rd_strobe_b, wr_strobe_b, ale;
    logic [15:0] dp_load_value, data_pointer, code_addr, rnd, v0, v1, a;
    logic [15:0] ca [4] = '{16'hF7FF, 16'hF800, 16'hFFFF, 16'h0000};
    int          bad_count, n_checks, cyc, n, slen;
    logic [2:0]  rexp;
    dpx_mem_ctrl dpx_mem_ctrl_i (.*);
    dpx_ext_mem  dpx_ext_mem_i (.*);
    assign p0_in = p0_oe ? p0_out : p0_drv;
    initial begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    // Order: lower RAM, upper RAM, special registers
    function automatic logic [2:0] route_exp(input logic [7:0] ad, input logic dr, sk);
        return {!ad[7], ad[7] && (!dr || sk), ad[7] && dr && !sk};
    endfunction
    task automatic end_sim();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [15:0] seen, exp);
        n_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("mismatch %s exp %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic sw(input logic [7:0] ad, dt);
        @(negedge clock);
        {sfr_addr, sfr_wdata, sfr_wr} = {ad, dt, 1'b1};
        @(negedge clock);
        sfr_wr = 1'b0;
    endtask
    task automatic sr(input logic [7:0] ad);
        @(negedge clock);
        {sfr_addr, sfr_rd} = {ad, 1'b1};
        @(negedge clock);
        sfr_rd = 1'b0;
        d = sfr_rdata;
    endtask
    task automatic ld(input logic [15:0] v, input logic inc);
        @(negedge clock);
        {dp_load, dp_inc, dp_load_value} = {!inc, inc, v};
        @(negedge clock);
        {dp_load, dp_inc} = 2'b00;
    endtask
    task automatic tog(input logic [7:0] ex);
        sr(PTR_BOOT_ADDR);
        sw(PTR_BOOT_ADDR, (d + 8'h01) & 8'h2D);
        sr(PTR_BOOT_ADDR);
        chk("select", d, ex);
    endtask
    task automatic xm(input logic wr, ptr, input logic [7:0] ri, wd, input logic ext);
        @(negedge clock);
        {xm_req, xm_write, xm_use_ptr, xm_ri_addr, xm_wdata} = {1'b1, wr, ptr, ri, wd};
        @(negedge clock);
        xm_req = 1'b0;
        n = 1;
        while (xm_done !== 1'b1 && n < 40) begin
            @(negedge clock);
            n++;
        end
        chk("latency", n, ext ? slen + 2 : 2);
        chk("external", xm_external, ext);
    endtask
    always @(posedge clock) begin
        cyc++;
        if (cyc == 5000) begin
            bad_count++;
            end_sim();
        end
    end
    initial begin
        {rst_b, hsb_off_chip, double_speed_mode, sfr_addr, sfr_wdata, sfr_wr, sfr_rd} = '0;
        {dp_load, dp_load_value, dp_inc, code_addr, iram_req, iram_addr} = '0;
        {iram_direct, iram_stack, xm_req, xm_write, xm_use_ptr, xm_ri_addr, xm_wdata} = '0;
        rnd = 16'h0043;
        repeat (4) @(negedge clock);
        rst_b = 1'b1;
        repeat (2) @(negedge clock);
        sr(MEM_CTRL_ADDR);
        chk("ctrl reset", d, 8'h00);
        sr(PTR_BOOT_ADDR);
        chk("ptr reset", d, 8'h00);
        sr(8'h8F);
        chk("unmapped", {sfr_hit, d}, 9'h000);
        for (int m = 0; m < 3; m++) begin
            double_speed_mode = (m == 1);
            if (m == 2) sw(MEM_CTRL_ADDR, 8'h01);
            repeat (12) @(negedge clock);
            n = 0;
            repeat (30) begin
                @(negedge clock);
                n += ale;
            end
            chk("latch count", n, m == 2 ? 0 : (m == 1 ? 10 : 5));
        end
        sw(PTR_BOOT_ADDR, 8'h2D);
        sr(PTR_BOOT_ADDR);
        chk("ptr reg", d, 8'h29);
        rnd = lfsr(rnd);
        v1 = rnd;
        ld(v1, 1'b0);
        tog(8'h28);
        rnd = lfsr(rnd);
        v0 = rnd;
        ld(v0, 1'b0);
        chk("dp zero", data_pointer, v0);
        tog(8'h29);
        chk("dp one", data_pointer, v1);
        ld(16'h0000, 1'b1);
        chk("dp inc", data_pointer, v1 + 16'h0001);
        tog(8'h28);
        chk("dp kept", data_pointer, v0);
        for (int b = 1; b >= 0; b--) begin
            if (b == 0) sw(PTR_BOOT_ADDR, 8'h00);
            for (int k = 0; k < 6; k++) begin
                @(negedge clock);
                rnd = lfsr(rnd);
                code_addr = k < 4 ? ca[k] : rnd;
                #1 chk("boot", boot_rom_sel, b == 1 && code_addr >= BOOT_BASE);
            end
        end
        for (int k = 0; k < 24; k++) begin
            @(negedge clock);
            rnd = lfsr(rnd);
            {iram_req, iram_direct, iram_stack, iram_addr} = {1'b1, rnd[9:8], rnd[7:0]};
            rexp = route_exp(iram_addr, iram_direct, iram_stack);
            #1 chk("route", {sel_lower_ram, sel_upper_ram, sel_special_reg}, rexp);
        end
        // Boundary of each size: last on-chip byte, then first external one
        for (int s = 0; s < 4; s++) begin
            sw(MEM_CTRL_ADDR, {2'h0, s == 3, 1'b0, s[1:0], 2'h1});
            slen = s == 3 ? 30 : 6;
            for (int e = 0; e < 2; e++) begin
                a = {6'h00, s[1:0], 8'hFF} + 16'(e);
                rnd = lfsr(rnd);
                ld(a, 1'b0);
                xm(1'b1, 1'b1, 8'h00, rnd[7:0], e == 1);
                xm(1'b0, 1'b1, 8'h00, 8'h00, e == 1);
                chk("rdata", xm_rdata, rnd[7:0]);
            end
        end
        ld(16'h00A5, 1'b0);
        xm(1'b1, 1'b1, 8'h00, 8'h3C, 1'b0);
        xm(1'b0, 1'b0, 8'hA5, 8'h00, 1'b0);
        chk("ri onchip", xm_rdata, 8'h3C);
        sw(MEM_CTRL_ADDR, 8'h03);
        slen = 6;
        xm(1'b1, 1'b0, 8'h5A, 8'hC3, 1'b1);
        xm(1'b0, 1'b0, 8'h5A, 8'h00, 1'b1);
        chk("ri ext", xm_rdata, 8'hC3);
        ld(16'h0010, 1'b0);
        xm(1'b1, 1'b1, 8'h00, 8'h96, 1'b1);
        xm(1'b0, 1'b1, 8'h00, 8'h00, 1'b1);
        chk("ptr ext", xm_rdata, 8'h96);
        rst_b = 1'b0;
        hsb_off_chip = 1'b1;
        repeat (2) @(negedge clock);
        rst_b = 1'b1;
        repeat (2) @(negedge clock);
        sr(MEM_CTRL_ADDR);
        chk("strap", d, 8'h02);
        end_sim();
    end
endmodule // testbench
bind dpx_mem_ctrl dpx_mem_chk dpx_mem_chk_i (.*);
`default_nettype wire
